// file: shift_rotate_execute.sv
// Fetch-phase executor for the single-word shift-rotate group.
// Assumes a host that writes the fetched instruction word over the plain
// register port; one clock is one machine time period T0 to T7.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module shift_rotate_execute
  import shift_rotate_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [WORD_W-1:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [WORD_W-1:0] rdata,
  input wire logic loop_switch,
  input wire logic interrupt_in_progress,
  output logic extend_lamp,
  output logic [2:0] next_phase,
  output logic cycle_done,
  output logic shift_group_decode,
  output logic operation_zero_decode,
  output logic read_accum_a_to_result_bus,
  output logic read_accum_b_to_result_bus,
  output logic shift_left_one_ctl,
  output logic shift_right_one_ctl,
  output logic store_accum_a_strobe,
  output logic store_accum_b_strobe,
  output logic read_pc_to_result_bus,
  output logic increment_carry_in,
  output logic adder_function_select,
  output logic store_program_counter,
  output logic store_memory_address,
  output logic [WORD_W-1:0] result_bus,
  output logic [WORD_W-1:0] transfer_bus
);

  // Machine state
  time_period_t state, next_state;
  logic [WORD_W-1:0] mem_word, next_mem_word; // Word handed in by the host
  logic [WORD_W-1:0] xfer_reg, next_xfer_reg; // Transfer register
  logic [5:0] instr_reg, next_instr_reg; // Bits 15..10 of the instruction
  logic [WORD_W-1:0] accum_a, next_accum_a;
  logic [WORD_W-1:0] accum_b, next_accum_b;
  logic [WORD_W-1:0] prog_counter, next_prog_counter;
  logic [WORD_W-1:0] mem_addr, next_mem_addr;
  logic extend, next_extend;
  logic skip_taken, next_skip_taken; // Skip carry seen this cycle
  logic [2:0] phase, next_phase_reg;
  logic [WORD_W-1:0] next_rdata;

  // Control values of the current period, registered onto the outputs
  logic ctl_group, ctl_opzero, ctl_read_a, ctl_read_b;
  logic ctl_left, ctl_right, ctl_store_a, ctl_store_b;
  logic ctl_read_pc, ctl_carry, ctl_adder, ctl_store_pc, ctl_store_mar;
  logic ctl_done;
  logic [WORD_W-1:0] rbus, tbus;

  // Loop switch synchroniser, three flops plus agreement filter
  logic loop_meta, loop_s2, loop_s3, loop_level;
  logic next_loop_level;

  // Decode and shifter wiring
  logic group_hit, sel_b, first_slot, second_slot;
  logic [WORD_W-1:0] acc_sel;
  logic sh_enable;
  logic [2:0] sh_op;
  logic [WORD_W-1:0] sh_word;
  logic sh_extend, sh_extend_load, sh_store, sh_left, sh_right;
  logic [WORD_W-1:0] pc_sum; // P plus carry, plus the held skip carry

  // Group hit on either accumulator code
  assign group_hit = (instr_reg == GROUP_A_CODE) || (instr_reg == GROUP_B_CODE);
  assign sel_b = (instr_reg == GROUP_B_CODE);
  assign acc_sel = sel_b ? accum_b : accum_a;
  assign first_slot = (state == ST_T3);
  assign second_slot = (state == ST_T5);
  // Skip carry from T4 joins the T6 add; loop mode drops both
  assign pc_sum = prog_counter + {15'h0000, !loop_level} + {15'h0000, skip_taken && !loop_level};

  // Slot picks the field: bits 9..6 first, bits 4, 2..0 second
  assign sh_enable = group_hit && (first_slot ? xfer_reg[FIRST_EN_BIT] :
                                   (second_slot && xfer_reg[SECOND_EN_BIT]));
  assign sh_op = first_slot ? xfer_reg[FIRST_OP_HI:FIRST_OP_LO] : xfer_reg[SECOND_OP_HI:SECOND_OP_LO];

  // One shifter shared by both shift slots
  shift_unit u_shift (
    .enable(sh_enable),
    .op(sh_op),
    .word_in(acc_sel),
    .extend_in(extend),
    .word_out(sh_word),
    .extend_out(sh_extend),
    .extend_load(sh_extend_load),
    .store(sh_store),
    .left_ctl(sh_left),
    .right_ctl(sh_right)
  );

  // Loop switch filter: level changes only when stages two and three agree
  always_comb begin
    next_loop_level = loop_level;
    if (loop_s2 == loop_s3) begin
      next_loop_level = loop_s3;
    end
  end

  // Loop switch registers
  always_ff @(posedge clk) begin
    if (srst) begin
      loop_meta <= 1'b0;
      loop_s2 <= 1'b0;
      loop_s3 <= 1'b0;
      loop_level <= 1'b0;
    end else begin
      loop_meta <= loop_switch;
      loop_s2 <= loop_meta;
      loop_s3 <= loop_s2;
      loop_level <= next_loop_level;
    end
  end

  // Sequencer and datapath next values
  always_comb begin
    next_state = state;
    next_mem_word = mem_word;
    next_xfer_reg = xfer_reg;
    next_instr_reg = instr_reg;
    next_accum_a = accum_a;
    next_accum_b = accum_b;
    next_prog_counter = prog_counter;
    next_mem_addr = mem_addr;
    next_extend = extend;
    next_skip_taken = skip_taken;
    next_phase_reg = phase;
    ctl_group = 1'b0;
    ctl_opzero = 1'b0;
    ctl_read_a = 1'b0;
    ctl_read_b = 1'b0;
    ctl_left = 1'b0;
    ctl_right = 1'b0;
    ctl_store_a = 1'b0;
    ctl_store_b = 1'b0;
    ctl_read_pc = 1'b0;
    ctl_carry = 1'b0;
    ctl_adder = 1'b0;
    ctl_store_pc = 1'b0;
    ctl_store_mar = 1'b0;
    ctl_done = 1'b0;
    rbus = WORD_RESET;
    tbus = WORD_RESET;
    case (state)
      ST_IDLE: begin
        // Host writes only land while idle, so no race with the core
        if (wr_strobe) begin
          if (addr == OFF_ACCUM_A) begin
            next_accum_a = wdata;
          end else if (addr == OFF_ACCUM_B) begin
            next_accum_b = wdata;
          end else if (addr == OFF_PC) begin
            next_prog_counter = wdata;
          end else if (addr == OFF_MAR) begin
            next_mem_addr = wdata;
          end else if (addr == OFF_EXTEND) begin
            next_extend = wdata[0];
          end else if (addr == OFF_INSTR) begin
            // Instruction word arrives, fetch cycle begins
            next_mem_word = wdata;
            next_skip_taken = 1'b0;
            next_state = ST_T0;
          end
        end
      end
      ST_T0: begin
        // Clear transfer register
        next_xfer_reg = WORD_RESET;
        next_state = ST_T1;
      end
      ST_T1: begin
        // Memory word into transfer register, instruction register cleared
        next_xfer_reg = mem_word;
        next_instr_reg = 6'h00;
        next_state = ST_T2;
      end
      ST_T2: begin
        // Opcode bits into the instruction register
        next_instr_reg = xfer_reg[IR_HI:IR_LO];
        next_state = ST_T3;
      end
      ST_T3, ST_T5: begin
        // Shift slots: T3 first, T5 second
        if (group_hit) begin
          // Decode belongs to T3 only; T3 also drives read select without a shift
          if (first_slot) begin
            ctl_group = 1'b1;
            ctl_opzero = (xfer_reg[OPZERO_HI:OPZERO_LO] == 4'h0);
            ctl_read_a = !sel_b;
            ctl_read_b = sel_b;
            rbus = acc_sel;
          end
          if (sh_enable) begin
            // Accumulator onto result bus, through shifter
            ctl_read_a = !sel_b;
            ctl_read_b = sel_b;
            rbus = acc_sel;
            tbus = sh_word;
            ctl_left = sh_left;
            ctl_right = sh_right;
            // Store back to the accumulator that was read
            if (sh_store) begin
              ctl_store_a = !sel_b;
              ctl_store_b = sel_b;
              if (sel_b) begin
                next_accum_b = sh_word;
              end else begin
                next_accum_a = sh_word;
              end
            end
            // Extend moves only for extend rotates
            if (sh_extend_load) begin
              next_extend = sh_extend;
            end
          end
        end
        next_state = (state == ST_T3) ? ST_T4 : ST_T6;
      end
      ST_T4: begin
        if (group_hit) begin
          // Clear extend on bit 5
          if (xfer_reg[CLE_BIT]) begin
            next_extend = 1'b0;
          end
          // Skip test reads the accumulator
          if (xfer_reg[SLA_BIT]) begin
            ctl_read_a = !sel_b;
            ctl_read_b = sel_b;
            rbus = acc_sel;
            // Lsb zero raises the carry; held for the T6 adder
            if (!acc_sel[0]) begin
              next_skip_taken = 1'b1;
              ctl_carry = !loop_level;
            end
          end
        end
        next_state = ST_T5;
      end
      ST_T6: begin
        // P plus carry into P and M; loop mode holds P and loads M with it
        ctl_read_pc = 1'b1;
        ctl_adder = 1'b1;
        ctl_carry = !loop_level;
        ctl_store_pc = 1'b1;
        ctl_store_mar = 1'b1;
        rbus = prog_counter;
        tbus = pc_sum;
        next_prog_counter = pc_sum;
        next_mem_addr = pc_sum;
        next_state = ST_T7;
      end
      ST_T7: begin
        // Choose next phase
        next_phase_reg = interrupt_in_progress ? PHASE_INTERRUPT : PHASE_FETCH;
        ctl_done = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Read data mux; unmapped addresses read zero, data valid one cycle only
  always_comb begin
    next_rdata = WORD_RESET;
    if (rd_strobe) begin
      if (addr == OFF_ACCUM_A) begin
        next_rdata = accum_a;
      end else if (addr == OFF_ACCUM_B) begin
        next_rdata = accum_b;
      end else if (addr == OFF_PC) begin
        next_rdata = prog_counter;
      end else if (addr == OFF_MAR) begin
        next_rdata = mem_addr;
      end else if (addr == OFF_EXTEND) begin
        next_rdata = {15'h0000, extend};
      end else if (addr == OFF_STATUS) begin
        next_rdata[STAT_BUSY_BIT] = (state != ST_IDLE);
        next_rdata[STAT_EXTEND_BIT] = extend;
        next_rdata[STAT_SKIP_BIT] = skip_taken;
        next_rdata[STAT_LOOP_BIT] = loop_level;
        next_rdata[STAT_PHASE_HI:STAT_PHASE_LO] = phase;
        next_rdata[STAT_GROUP_BIT] = group_hit;
      end else if (addr == OFF_INSTR) begin
        next_rdata = mem_word;
      end
    end
  end

  // State, datapath and output registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      mem_word <= WORD_RESET;
      xfer_reg <= WORD_RESET;
      instr_reg <= 6'h00;
      accum_a <= WORD_RESET;
      accum_b <= WORD_RESET;
      prog_counter <= WORD_RESET;
      mem_addr <= WORD_RESET;
      extend <= EXTEND_RESET;
      skip_taken <= 1'b0;
      phase <= PHASE_RESET;
      rdata <= WORD_RESET;
      extend_lamp <= EXTEND_RESET;
      next_phase <= PHASE_RESET;
      cycle_done <= 1'b0;
      shift_group_decode <= 1'b0;
      operation_zero_decode <= 1'b0;
      read_accum_a_to_result_bus <= 1'b0;
      read_accum_b_to_result_bus <= 1'b0;
      shift_left_one_ctl <= 1'b0;
      shift_right_one_ctl <= 1'b0;
      store_accum_a_strobe <= 1'b0;
      store_accum_b_strobe <= 1'b0;
      read_pc_to_result_bus <= 1'b0;
      increment_carry_in <= 1'b0;
      adder_function_select <= 1'b0;
      store_program_counter <= 1'b0;
      store_memory_address <= 1'b0;
      result_bus <= WORD_RESET;
      transfer_bus <= WORD_RESET;
    end else begin
      state <= next_state;
      mem_word <= next_mem_word;
      xfer_reg <= next_xfer_reg;
      instr_reg <= next_instr_reg;
      accum_a <= next_accum_a;
      accum_b <= next_accum_b;
      prog_counter <= next_prog_counter;
      mem_addr <= next_mem_addr;
      extend <= next_extend;
      skip_taken <= next_skip_taken;
      phase <= next_phase_reg;
      rdata <= next_rdata;
      // Lamp tracks the extend flop directly
      extend_lamp <= next_extend;
      next_phase <= next_phase_reg;
      cycle_done <= ctl_done;
      // Control outputs trail their period by one clock
      shift_group_decode <= ctl_group;
      operation_zero_decode <= ctl_opzero;
      read_accum_a_to_result_bus <= ctl_read_a;
      read_accum_b_to_result_bus <= ctl_read_b;
      shift_left_one_ctl <= ctl_left;
      shift_right_one_ctl <= ctl_right;
      store_accum_a_strobe <= ctl_store_a;
      store_accum_b_strobe <= ctl_store_b;
      read_pc_to_result_bus <= ctl_read_pc;
      increment_carry_in <= ctl_carry;
      adder_function_select <= ctl_adder;
      store_program_counter <= ctl_store_pc;
      store_memory_address <= ctl_store_mar;
      result_bus <= rbus;
      transfer_bus <= tbus;
    end
  end

endmodule

// file: shift_rotate_pkg.sv
// Shared constants for the shift-rotate execute block: register map,
// instruction field positions, operation codes, phases and state codes.
// Assumes a 16-bit machine word and one clock per machine time period.
package shift_rotate_pkg;

  // Machine word width
  localparam int WORD_W = 16;

  // Register port byte offsets, one aligned word each
  localparam logic [7:0] OFF_ACCUM_A = 8'h00;
  localparam logic [7:0] OFF_ACCUM_B = 8'h04;
  localparam logic [7:0] OFF_PC = 8'h08;
  localparam logic [7:0] OFF_MAR = 8'h0C;
  localparam logic [7:0] OFF_EXTEND = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_INSTR = 8'h18;

  // Status register bit positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_EXTEND_BIT = 1;
  localparam int STAT_SKIP_BIT = 2;
  localparam int STAT_LOOP_BIT = 3;
  localparam int STAT_PHASE_LO = 4;
  localparam int STAT_PHASE_HI = 6;
  localparam int STAT_GROUP_BIT = 7;

  // Instruction field positions
  localparam int IR_HI = 15;
  localparam int IR_LO = 10;
  localparam int OPZERO_HI = 15;
  localparam int OPZERO_LO = 12;
  localparam int FIRST_EN_BIT = 9;
  localparam int FIRST_OP_HI = 8;
  localparam int FIRST_OP_LO = 6;
  localparam int CLE_BIT = 5;
  localparam int SECOND_EN_BIT = 4;
  localparam int SLA_BIT = 3;
  localparam int SECOND_OP_HI = 2;
  localparam int SECOND_OP_LO = 0;

  // Group codes seen in instruction bits 15..10
  localparam logic [5:0] GROUP_A_CODE = 6'h00;
  localparam logic [5:0] GROUP_B_CODE = 6'h02;

  // Shifter operation codes implemented here
  localparam logic [2:0] OP_ARITH_LEFT = 3'h4;
  localparam logic [2:0] OP_EXT_ROT_RIGHT = 3'h5;

  // Phase numbers
  localparam logic [2:0] PHASE_FETCH = 3'h1;
  localparam logic [2:0] PHASE_INTERRUPT = 3'h4;

  // Reset values
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic EXTEND_RESET = 1'b0;
  localparam logic [2:0] PHASE_RESET = 3'h1;

  // Machine time periods, one-hot
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_T0 = 9'h002,
    ST_T1 = 9'h004,
    ST_T2 = 9'h008,
    ST_T3 = 9'h010,
    ST_T4 = 9'h020,
    ST_T5 = 9'h040,
    ST_T6 = 9'h080,
    ST_T7 = 9'h100
  } time_period_t;

endpackage

// file: shift_unit.sv
// Single-place shifter between the result bus and the transfer bus.
// Assumes the caller presents one operation per cycle and stores the
// outputs itself; this module is purely combinational.
`timescale 1ns/1ps
module shift_unit
  import shift_rotate_pkg::*;
(
  input wire logic enable,
  input wire logic [2:0] op,
  input wire logic [WORD_W-1:0] word_in,
  input wire logic extend_in,
  output logic [WORD_W-1:0] word_out,
  output logic extend_out,
  output logic extend_load,
  output logic store,
  output logic left_ctl,
  output logic right_ctl
);

  // Operation select; unknown codes pass the word and touch nothing
  always_comb begin
    word_out = word_in;
    extend_out = extend_in;
    extend_load = 1'b0;
    store = 1'b0;
    left_ctl = 1'b0;
    right_ctl = 1'b0;
    if (enable) begin
      case (op)
        OP_ARITH_LEFT: begin
          // Sign and bit 0 forced low, old bit 14 dropped
          word_out = {1'b0, word_in[13:0], 1'b0};
          store = 1'b1;
          left_ctl = 1'b1;
        end
        OP_EXT_ROT_RIGHT: begin
          // Extend enters bit 15, bit 0 leaves into extend
          word_out = {extend_in, word_in[WORD_W-1:1]};
          // Extend follows the result bus lsb
          extend_out = word_in[0];
          extend_load = 1'b1;
          store = 1'b1;
          right_ctl = 1'b1;
        end
        default: begin
          // Other rotates are not implemented; word and extend kept
          word_out = word_in;
        end
      endcase
    end
  end

endmodule

// file: shift_rotate_execute_properties.sv
// Concurrent checks on the shift-rotate executor's output ports.
// Assumes registered control pulses lagging their period by one clock.
`timescale 1ns/1ps
module shift_rotate_execute_checker
  import shift_rotate_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic interrupt_in_progress,
  input wire logic extend_lamp,
  input wire logic [2:0] next_phase,
  input wire logic cycle_done,
  input wire logic shift_group_decode,
  input wire logic operation_zero_decode,
  input wire logic read_accum_a_to_result_bus,
  input wire logic read_accum_b_to_result_bus,
  input wire logic shift_left_one_ctl,
  input wire logic shift_right_one_ctl,
  input wire logic store_accum_a_strobe,
  input wire logic store_accum_b_strobe,
  input wire logic read_pc_to_result_bus,
  input wire logic adder_function_select,
  input wire logic store_program_counter,
  input wire logic store_memory_address,
  input wire logic [WORD_W-1:0] result_bus,
  input wire logic [WORD_W-1:0] transfer_bus
);
  // One clock domain, reset masks every check
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Store goes back to the accumulator that was read
  property p_store_a;
    store_accum_a_strobe |-> read_accum_a_to_result_bus && !store_accum_b_strobe;
  endproperty
  a_store_a: assert property (p_store_a) else $error("A store without A read");
  property p_store_b;
    store_accum_b_strobe |-> read_accum_b_to_result_bus && !store_accum_a_strobe;
  endproperty
  a_store_b: assert property (p_store_b) else $error("B store without B read");
  // Left shift keeps sign slot clear and drops bit 14
  property p_alr;
    shift_left_one_ctl |-> transfer_bus == {1'b0, result_bus[13:0], 1'b0};
  endproperty
  a_alr: assert property (p_alr) else $error("arith left result wrong");
  // Right rotate takes the extend value held before it into bit 15
  property p_era;
    shift_right_one_ctl |-> transfer_bus == {$past(extend_lamp), result_bus[15:1]};
  endproperty
  a_era: assert property (p_era) else $error("rotate right result wrong");
  property p_era_ext;
    shift_right_one_ctl |-> extend_lamp == result_bus[0];
  endproperty
  a_era_ext: assert property (p_era_ext) else $error("extend not from lsb");
  // Group decode comes with exactly one read select
  property p_group;
    shift_group_decode |-> operation_zero_decode && (read_accum_a_to_result_bus ^ read_accum_b_to_result_bus);
  endproperty
  a_group: assert property (p_group) else $error("group decode signals wrong");
  // T3 decode leads the end of cycle by four periods
  property p_group_done;
    shift_group_decode |-> ##4 cycle_done;
  endproperty
  a_group_done: assert property (p_group_done) else $error("slot order wrong");
  property p_pc_store;
    store_program_counter |-> store_memory_address && read_pc_to_result_bus && adder_function_select;
  endproperty
  a_pc_store: assert property (p_pc_store) else $error("increment strobes apart");
  property p_done_pc;
    cycle_done |-> $past(store_program_counter);
  endproperty
  a_done_pc: assert property (p_done_pc) else $error("done without increment");
  // Phase choice follows the interrupt level seen in T7
  property p_phase;
    cycle_done |-> next_phase == ($past(interrupt_in_progress) ? PHASE_INTERRUPT : PHASE_FETCH);
  endproperty
  a_phase: assert property (p_phase) else $error("next phase wrong");

  c_left: cover property (shift_left_one_ctl && store_accum_b_strobe);
  c_right: cover property (shift_right_one_ctl && store_accum_a_strobe);
  c_irq: cover property (cycle_done && next_phase == PHASE_INTERRUPT);
endmodule

bind shift_rotate_execute shift_rotate_execute_checker u_chk (.clk, .srst, .interrupt_in_progress,
  .extend_lamp, .next_phase, .cycle_done, .shift_group_decode, .operation_zero_decode,
  .read_accum_a_to_result_bus, .read_accum_b_to_result_bus, .shift_left_one_ctl, .shift_right_one_ctl,
  .store_accum_a_strobe, .store_accum_b_strobe, .read_pc_to_result_bus, .adder_function_select,
  .store_program_counter, .store_memory_address, .result_bus, .transfer_bus);

// file: phase_control_model.sv
// Behavioural phase control standing beside the executor.
// Assumes the bench raises irq_req as a level on the same clock.
`timescale 1ns/1ps
module phase_control_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic irq_req,
  input wire logic cycle_done,
  input wire logic [2:0] next_phase,
  output logic interrupt_in_progress,
  output logic [2:0] last_phase
);
  // Interrupt level is registered, so it never moves inside a T7 sample
  always_ff @(posedge clk) begin
    if (srst) begin
      interrupt_in_progress <= 1'b0;
      last_phase <= 3'h1;
    end else begin
      interrupt_in_progress <= irq_req;
      // Phase taken over when the cycle ends
      if (cycle_done) begin
        last_phase <= next_phase;
      end
    end
  end
endmodule

// file: test_shift_rotate_execute.sv
// Self-checking bench for the shift-rotate executor.
// Assumes the host port, loop switch and interrupt request are driven here.
`timescale 1ns/1ps
module test_shift_rotate_execute
  import shift_rotate_pkg::*;
;
  logic clk = 0, srst = 1, wr_strobe = 0, rd_strobe = 0, loop_switch = 0, irq_req = 0, rd_d = 0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, result_bus, transfer_bus;
  logic [2:0] next_phase, last_phase;
  logic extend_lamp, cycle_done, interrupt_in_progress, shift_group_decode, operation_zero_decode;
  logic read_accum_a_to_result_bus, read_accum_b_to_result_bus, shift_left_one_ctl, shift_right_one_ctl;
  logic store_accum_a_strobe, store_accum_b_strobe, read_pc_to_result_bus, increment_carry_in;
  logic adder_function_select, store_program_counter, store_memory_address;
  logic [15:0] rq[$]; // Expected read data, oldest first
  logic [16:0] tq[$]; // Expected {is_b, stored word}
  logic [15:0] a_m = 0, b_m = 0, p_m = 0, v; // Reference copies
  logic e_m = 0, loop_m = 0;
  int num_errors = 0, num_checks = 0, i;

  shift_rotate_execute dut (.clk, .srst, .addr, .wdata, .wr_strobe, .rd_strobe, .rdata, .loop_switch,
    .interrupt_in_progress, .extend_lamp, .next_phase, .cycle_done, .shift_group_decode,
    .operation_zero_decode, .read_accum_a_to_result_bus, .read_accum_b_to_result_bus,
    .shift_left_one_ctl, .shift_right_one_ctl, .store_accum_a_strobe, .store_accum_b_strobe,
    .read_pc_to_result_bus, .increment_carry_in, .adder_function_select, .store_program_counter,
    .store_memory_address, .result_bus, .transfer_bus);
  phase_control_model partner (.clk, .srst, .irq_req, .cycle_done, .next_phase,
    .interrupt_in_progress, .last_phase);

  // 50 MHz clock
  initial forever #10 clk = ~clk;

  task cmp(input string what, input logic [16:0] exp, input logic [16:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One-cycle strobes; the gap edge keeps back-to-back calls clean
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    rq.push_back(exp);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
  endtask

  // Reference shifter; unknown ops leave the word alone
  task slot(input logic [2:0] op, input logic isb);
    logic [15:0] w, r;
    w = isb ? b_m : a_m;
    if (op == OP_ARITH_LEFT) r = {1'b0, w[13:0], 1'b0};
    else if (op == OP_EXT_ROT_RIGHT) begin
      r = {e_m, w[15:1]};
      e_m = w[0];
    end else return;
    tq.push_back({isb, r});
    if (isb) b_m = r;
    else a_m = r;
  endtask

  // Runs one instruction; poke tries writes that busy must refuse
  task exec(input logic [15:0] ins, input logic poke);
    int n;
    if (ins[15:12] == 4'h0 && !ins[10]) begin
      if (ins[9]) slot(ins[8:6], ins[11]);
      if (ins[5]) e_m = 1'b0;
      if (ins[3] && !(ins[11] ? b_m[0] : a_m[0]) && !loop_m) p_m = p_m + 16'h0001;
      if (ins[4]) slot(ins[2:0], ins[11]);
    end
    if (!loop_m) p_m = p_m + 16'h0001;
    wr(OFF_INSTR, ins);
    if (poke) begin
      wr(OFF_ACCUM_A, 16'hFFFF);
      wr(OFF_INSTR, 16'h0340);
    end
    for (n = 0; n < 20 && cycle_done !== 1'b1; n++) @(posedge clk);
    if (n == 20) begin
      cmp("cycle_done wait", 17'h0, 17'h1);
      end_of_test;
    end
    cmp("next_phase", {14'h0, irq_req ? PHASE_INTERRUPT : PHASE_FETCH}, {14'h0, next_phase});
    cmp("extend_lamp", {16'h0, e_m}, {16'h0, extend_lamp});
    rd(OFF_ACCUM_A, a_m);
    rd(OFF_ACCUM_B, b_m);
    rd(OFF_PC, p_m);
    rd(OFF_MAR, p_m);
    rd(OFF_EXTEND, {15'h0, e_m});
  endtask

  // Result watcher: read data one cycle late, stores with their buses
  always @(posedge clk) begin
    if (rd_d) cmp("rdata", {1'b0, rq.size() ? rq.pop_front() : 16'hDEAD}, {1'b0, rdata});
    if (store_accum_a_strobe || store_accum_b_strobe)
      cmp("store", tq.size() ? tq.pop_front() : 17'h1DEAD, {store_accum_b_strobe, transfer_bus});
    if (store_memory_address)
      cmp("carry", {16'h0, !loop_m}, {16'h0, increment_carry_in});
    rd_d <= rd_strobe;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    cmp("watchdog", 17'h0, 17'h1);
    end_of_test;
  end

  initial begin
    void'($urandom(89293));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    // Reset values, unmapped slot reads zero
    for (i = 0; i < 8; i++) if (i != 5 && i != 6) rd(8'(i * 4), 16'h0000);
    cmp("reset phase", {14'h0, PHASE_FETCH}, {14'h0, next_phase});
    wr(OFF_ACCUM_A, 16'h5555);
    a_m = 16'h5555;
    exec(16'h0340, 1'b0);
    exec(16'h0340, 1'b0);
    wr(OFF_ACCUM_B, 16'hD555);
    b_m = 16'hD555;
    wr(OFF_EXTEND, 16'h0001);
    e_m = 1'b1;
    exec(16'h0B00, 1'b0);
    exec(16'h0B40, 1'b1);
    exec(16'h0300, 1'b0);
    wr(OFF_EXTEND, 16'h0001);
    e_m = 1'b1;
    exec(16'h0020, 1'b0);
    exec(16'h0008, 1'b0);
    exec(16'h0808, 1'b0);
    exec(16'h0355, 1'b0);
    exec(16'h1340, 1'b0);
    // Random words through both ops on both accumulators
    for (i = 0; i < 12; i++) begin
      v = 16'($urandom);
      wr(OFF_ACCUM_A, v);
      a_m = v;
      v = 16'($urandom);
      wr(OFF_ACCUM_B, v);
      b_m = v;
      exec({4'h0, 1'($urandom), 2'b01, 1'($urandom) ? OP_ARITH_LEFT : OP_EXT_ROT_RIGHT, 6'($urandom)}, 1'b0);
    end
    // Loop switch needs its filter to settle both ways
    loop_switch <= 1'b1;
    loop_m = 1'b1;
    repeat (8) @(posedge clk);
    exec(16'h0308, 1'b0);
    loop_switch <= 1'b0;
    loop_m = 1'b0;
    repeat (8) @(posedge clk);
    irq_req <= 1'b1;
    repeat (2) @(posedge clk);
    exec(16'h0300, 1'b0);
    cmp("partner phase", {14'h0, PHASE_INTERRUPT}, {14'h0, last_phase});
    irq_req <= 1'b0;
    repeat (2) @(posedge clk);
    exec(16'h0340, 1'b0);
    end_of_test;
  end
endmodule
